// ==== hw/lus_core.sv ====
// LIN/UART status, error, checksum, identifier and frame buffer block with APB registers
//
// Register access over APB and the address map were decided locally.
module lus_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input lus_pkg::lus_evt_s evt,
	output lus_pkg::lus_eng_s eng,
	output logic irq_ok,
	output logic irq_err
);
	typedef struct packed {
		lus_pkg::lus_ctrl_s ctrl;
		logic idok;
		logic txok;
		logic rxok;
		logic [2:0] fsc;
		lus_pkg::lus_err_s err;
		logic [3:0] ien;
		lus_pkg::lus_len_s len;
		logic [5:0] id;
		lus_pkg::lus_sel_s sel;
		logic [7:0][7:0] buffer;
		logic [7:0] uart_rx;
		logic rx_unread;
		lus_pkg::lus_phase_e phase;
		logic [3:0] cnt;
		logic [7:0] sum;
		logic start;
		logic stop;
		logic [7:0] txb;
		logic [31:0] prdata;
	} lus_state_s;

	lus_state_s state_r;
	lus_state_s state_nxt;
	logic busy;
	logic uart;
	logic err_sum;
	logic mapped;
	logic acc;
	lus_pkg::lus_status_s status;

	assign busy = state_r.phase != lus_pkg::LUS_PH_IDLE;
	assign uart = state_r.ctrl.command_field[2];
	assign err_sum = |state_r.err;
	assign status = '{frame_status_code: state_r.fsc, busy_status_bit: busy,
		error_summary_bit: err_sum, identifier_ok_flag: state_r.idok,
		transmit_complete_flag: state_r.txok, receive_complete_flag: state_r.rxok};
	assign mapped = paddr[1:0] == 2'h0 && paddr <= lus_pkg::LUS_OFS_DATA;
	assign acc = psel && penable && ce;
	// Wait states only while the clock enable freezes the block
	assign pready = ce;
	assign pslverr = psel && penable && !mapped;
	assign prdata = state_r.prdata;
	assign irq_ok = |({state_r.idok, state_r.txok, state_r.rxok} & state_r.ien[2:0]);
	assign irq_err = err_sum && state_r.ien[3];
	assign eng = '{start: state_r.start, stop: state_r.stop,
		command_field: state_r.ctrl.command_field, conf: state_r.ctrl.conf,
		tx_byte: state_r.txb, tx_pid: lus_pkg::lus_pid(state_r.id)};

	always_comb begin
		lus_state_s n;
		lus_pkg::lus_ctrl_s wc;
		lus_pkg::lus_err_s es;
		logic [7:0] rd;
		logic [7:0] wb;
		logic wr;
		logic nocrc;
		logic sw_rst;
		n = state_r;
		es = '0;
		rd = 8'h00;
		wb = pwdata[7:0];
		wc = lus_pkg::lus_ctrl_s'(wb);
		wr = acc && pwrite && mapped;
		nocrc = state_r.ctrl.conf == lus_pkg::LUS_CONF_NOCRC;
		sw_rst = 1'b0;
		n.start = 1'b0;
		n.stop = 1'b0;

		// Read data is latched in the setup cycle so it comes from flops
		if (paddr == lus_pkg::LUS_OFS_CTRL) begin
			rd = state_r.ctrl;
		end else if (paddr == lus_pkg::LUS_OFS_STATUS) begin
			rd = status;
		end else if (paddr == lus_pkg::LUS_OFS_IEN) begin
			rd = {4'h0, state_r.ien};
		end else if (paddr == lus_pkg::LUS_OFS_ERR) begin
			rd = state_r.err;
		end else if (paddr == lus_pkg::LUS_OFS_LEN) begin
			rd = state_r.len;
		end else if (paddr == lus_pkg::LUS_OFS_ID) begin
			rd = lus_pkg::lus_pid(state_r.id);
		end else if (paddr == lus_pkg::LUS_OFS_SEL) begin
			rd = {4'h0, state_r.sel};
		end else if (paddr == lus_pkg::LUS_OFS_DATA) begin
			rd = uart ? state_r.uart_rx : state_r.buffer[state_r.sel.buffer_index];
		end
		if (psel && !penable) begin
			n.prdata = {24'h000000, rd};
		end

		if (wr && paddr == lus_pkg::LUS_OFS_CTRL) begin
			if (wc.sw_reset) begin
				sw_rst = 1'b1;
			end else if (busy) begin
				// Only software reset, command and enable reach a busy controller
				if (!wc.enable) begin
					n.ctrl.enable = 1'b0;
					n.phase = lus_pkg::LUS_PH_IDLE;
					n.stop = 1'b1;
				end else if (wc.command_field == lus_pkg::LUS_CMD_RXHDR) begin
					es.abort_flag = 1'b1;
					n.ctrl.command_field = lus_pkg::LUS_CMD_RXHDR;
					n.phase = lus_pkg::LUS_PH_IDLE;
					n.stop = 1'b1;
				end else if (!uart) begin
					es.overrun_error_flag = 1'b1;
				end
			end else begin
				n.ctrl = wc;
				if (wc.enable && !wc.command_field[2]) begin
					if (wc.command_field == lus_pkg::LUS_CMD_TXHDR) begin
						n.phase = lus_pkg::LUS_PH_HDR;
						n.start = 1'b1;
					end else if (wc.command_field == lus_pkg::LUS_CMD_RXRSP) begin
						n.phase = lus_pkg::LUS_PH_RSP_RX;
						n.start = 1'b1;
						n.len.tx_length_field = '0;
						if (n.len.rx_length_field > lus_pkg::LUS_LEN_MAX) begin
							n.len.rx_length_field = lus_pkg::LUS_LEN_MAX;
						end
					end else if (wc.command_field == lus_pkg::LUS_CMD_TXRSP) begin
						n.phase = lus_pkg::LUS_PH_RSP_TX;
						n.start = 1'b1;
						n.len.rx_length_field = '0;
						if (n.len.tx_length_field > lus_pkg::LUS_LEN_MAX) begin
							n.len.tx_length_field = lus_pkg::LUS_LEN_MAX;
						end
					end
					n.cnt = '0;
					// Identifier joins the sum only under the newer protocol
					n.sum = wc.protocol_version_bit ? 8'h00 : lus_pkg::lus_pid(state_r.id);
				end
			end
		end

		if (wr && paddr == lus_pkg::LUS_OFS_STATUS) begin
			if (wb[0]) n.rxok = 1'b0;
			if (wb[1]) n.txok = 1'b0;
			if (wb[2]) n.idok = 1'b0;
			if (wb[3]) n.err = '0;
		end
		if (wr && paddr == lus_pkg::LUS_OFS_IEN) begin
			n.ien = wb[3:0];
		end
		if (wr && paddr == lus_pkg::LUS_OFS_LEN && !uart && !busy) begin
			n.len = wb;
		end
		if (wr && paddr == lus_pkg::LUS_OFS_ID && !busy) begin
			n.id = wb[5:0];
		end
		if (wr && paddr == lus_pkg::LUS_OFS_SEL) begin
			n.sel = wb[3:0];
		end
		if (acc && mapped && paddr == lus_pkg::LUS_OFS_DATA) begin
			if (uart) begin
				if (!pwrite) begin
					n.rx_unread = 1'b0;
				end else if (!busy && state_r.ctrl.enable && state_r.ctrl.command_field[0]) begin
					n.txb = wb;
					n.phase = lus_pkg::LUS_PH_UART_TX;
					n.start = 1'b1;
				end
			end else begin
				if (pwrite && !busy) begin
					n.buffer[state_r.sel.buffer_index] = wb;
				end
				if (!state_r.sel.auto_increment_disable) begin
					n.sel.buffer_index = state_r.sel.buffer_index + 3'h1;
				end
			end
		end

		if (state_r.ctrl.enable && !uart) begin
			if (evt.hdr_done && (state_r.phase == lus_pkg::LUS_PH_HDR ||
				(state_r.phase == lus_pkg::LUS_PH_IDLE &&
				state_r.ctrl.command_field == lus_pkg::LUS_CMD_RXHDR))) begin
				n.id = evt.hdr_pid[5:0];
				n.fsc = (evt.hdr_pid[5:2] == lus_pkg::LUS_SPECIAL_ID) ?
					{1'b1, evt.hdr_pid[1:0]} : 3'h0;
				if (state_r.phase == lus_pkg::LUS_PH_IDLE &&
					lus_pkg::lus_pid(evt.hdr_pid[5:0]) != evt.hdr_pid) begin
					es.parity_error_flag = 1'b1;
				end
				if (state_r.ctrl.protocol_version_bit) begin
					n.len.rx_length_field = evt.hdr_pid[5] ? (evt.hdr_pid[4] ?
						lus_pkg::LUS_LEN_MAX : 4'h4) : 4'h2;
					n.len.tx_length_field = n.len.rx_length_field;
				end
				n.idok = 1'b1;
				n.phase = lus_pkg::LUS_PH_IDLE;
			end
			if (evt.rx_byte_vld && state_r.phase == lus_pkg::LUS_PH_RSP_RX) begin
				if (state_r.cnt == state_r.len.rx_length_field) begin
					if (lus_pkg::lus_cks_add(state_r.sum, evt.rx_byte) != lus_pkg::LUS_CKS_OK) begin
						es.checksum_error_flag = 1'b1;
					end else begin
						n.rxok = 1'b1;
					end
					n.phase = lus_pkg::LUS_PH_IDLE;
				end else begin
					n.buffer[state_r.cnt[2:0]] = evt.rx_byte;
					n.sum = lus_pkg::lus_cks_add(state_r.sum, evt.rx_byte);
					n.cnt = state_r.cnt + 4'h1;
					n.len.tx_length_field = n.cnt;
					if (nocrc && n.cnt == state_r.len.rx_length_field) begin
						n.rxok = 1'b1;
						n.phase = lus_pkg::LUS_PH_IDLE;
					end
				end
			end
			if (evt.tx_byte_done && state_r.phase == lus_pkg::LUS_PH_RSP_TX) begin
				if (state_r.cnt == state_r.len.tx_length_field) begin
					n.txok = 1'b1;
					n.phase = lus_pkg::LUS_PH_IDLE;
				end else begin
					n.sum = lus_pkg::lus_cks_add(state_r.sum, state_r.txb);
					n.cnt = state_r.cnt + 4'h1;
					n.len.rx_length_field = n.cnt;
					if (nocrc && n.cnt == state_r.len.tx_length_field) begin
						n.txok = 1'b1;
						n.phase = lus_pkg::LUS_PH_IDLE;
					end
				end
			end
			if (evt.bit_vld && busy && evt.bit_drv != evt.bit_smp) begin
				es.bit_error_flag = 1'b1;
			end
			if (evt.sync_bad) begin
				es.sync_error_flag = 1'b1;
			end
			if (evt.frame_over && state_r.ctrl.conf != lus_pkg::LUS_CONF_NOCRC &&
				state_r.ctrl.conf != lus_pkg::LUS_CONF_NOTO) begin
				es.timeout_error_flag = 1'b1;
			end
			if (evt.break_sync) begin
				if (state_r.phase == lus_pkg::LUS_PH_RSP_TX) begin
					es.bit_error_flag = 1'b1;
				end else if (state_r.phase == lus_pkg::LUS_PH_RSP_RX) begin
					es.framing_error_flag = 1'b1;
				end
			end
		end
		if (state_r.ctrl.enable && uart) begin
			if (evt.rx_byte_vld && state_r.ctrl.command_field[1]) begin
				if (state_r.rx_unread) begin
					es.overrun_error_flag = 1'b1;
				end
				n.uart_rx = evt.rx_byte;
				n.rx_unread = 1'b1;
				n.rxok = 1'b1;
			end
			if (evt.tx_byte_done && state_r.phase == lus_pkg::LUS_PH_UART_TX) begin
				n.txok = 1'b1;
				n.phase = lus_pkg::LUS_PH_IDLE;
			end
		end
		if (state_r.ctrl.enable && evt.stop_dominant) begin
			es.framing_error_flag = 1'b1;
		end

		// Hardware sets win over a clear in the same cycle
		n.err = n.err | es;
		if (!uart && (es & ~8'h80) != 8'h00) begin
			n.ctrl.command_field = lus_pkg::LUS_CMD_RXHDR;
			n.phase = lus_pkg::LUS_PH_IDLE;
			n.stop = 1'b1;
		end
		if (n.ctrl.command_field[2]) begin
			n.len = '0;
		end
		if (!uart && n.phase == lus_pkg::LUS_PH_RSP_TX) begin
			n.txb = (n.cnt == n.len.tx_length_field) ? ~n.sum : n.buffer[n.cnt[2:0]];
		end
		if (sw_rst) begin
			n = '0;
		end
		state_nxt = n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= '0;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !ce);

	logic st_wr;
	logic lin_hdr;
	assign st_wr = acc && pwrite && paddr == lus_pkg::LUS_OFS_STATUS;
	assign lin_hdr = state_r.ctrl.enable && !uart && evt.hdr_done &&
		(state_r.phase == lus_pkg::LUS_PH_HDR || (state_r.phase == lus_pkg::LUS_PH_IDLE &&
		state_r.ctrl.command_field == lus_pkg::LUS_CMD_RXHDR));

	sequence s_status_setup;
		psel && !penable && paddr == lus_pkg::LUS_OFS_STATUS;
	endsequence
	property p_err_sum;
		s_status_setup ##1 1'b1 |-> prdata[3] == $past(|state_r.err);
	endproperty
	a_err_sum: assert property (p_err_sum) else $error("summary differs from flags");

	property p_uart_len;
		uart |-> state_r.len == 8'h00;
	endproperty
	a_uart_len: assert property (p_uart_len) else $error("length nonzero in UART mode");

	property p_idok;
		lin_hdr && !(st_wr && pwdata[2]) |=> state_r.idok && !busy;
	endproperty
	a_idok: assert property (p_idok) else $error("id-ok not set after header");

	property p_bit_err;
		state_r.ctrl.enable && !uart && busy && evt.bit_vld && evt.bit_drv != evt.bit_smp
			|=> state_r.err.bit_error_flag && !busy && state_r.ctrl.command_field == 3'h0;
	endproperty
	a_bit_err: assert property (p_bit_err) else $error("bit error not handled");

	property p_parity;
		lin_hdr && state_r.phase == lus_pkg::LUS_PH_IDLE &&
			lus_pkg::lus_pid(evt.hdr_pid[5:0]) != evt.hdr_pid |=> state_r.err.parity_error_flag;
	endproperty
	a_parity: assert property (p_parity) else $error("parity error missed");

	property p_err_clear;
		st_wr && pwdata[3] && !evt.bit_vld && !evt.sync_bad && !evt.stop_dominant &&
			!evt.frame_over && !evt.break_sync && !evt.rx_byte_vld && !evt.hdr_done
			&& paddr == lus_pkg::LUS_OFS_STATUS |=> state_r.err == 8'h00;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("errors not cleared");

	sequence s_abort_write;
		acc && pwrite && paddr == lus_pkg::LUS_OFS_CTRL && busy && pwdata[3] &&
			pwdata[2:0] == 3'h0 && !pwdata[7];
	endsequence
	property p_abort;
		s_abort_write |=> state_r.err.abort_flag && !busy ##1 !state_r.stop;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not recorded");

	property p_irq;
		irq_ok == ((state_r.idok && state_r.ien[2]) || (state_r.txok && state_r.ien[1]) ||
			(state_r.rxok && state_r.ien[0]));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt merge wrong");

	property p_fsc;
		lin_hdr && evt.hdr_pid[5:0] == 6'h3D |=> state_r.fsc == 3'h5;
	endproperty
	a_fsc: assert property (p_fsc) else $error("frame status code wrong");

	property p_autoinc;
		acc && !uart && paddr == lus_pkg::LUS_OFS_DATA && !state_r.sel.auto_increment_disable
			|=> state_r.sel.buffer_index == $past(state_r.sel.buffer_index) + 3'h1;
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("index did not advance");
endmodule // lus_core

// ==== hw/lus_pkg.sv ====
// Constants, register map and carrier types of the LIN/UART status, error and buffer block
//
// Behaviour
// - UART mode or reset: lengths zero, writes ignored
// - Header end sets id-ok; 1.3 updates lengths
// - Response or character end sets rx/tx complete
// - Error summary is OR of eight flags
// - Bit readback mismatch flags error, aborts transmit
// - Received checksum not summing to FF flags error
// - Identifier parity mismatch flagged, never corrected
// - Slave sync field edges off tolerance flagged
// - Dominant stop bit flags framing error
// - Frame exceeding maximum duration flags time-out
// - Command while busy, or UART overwrite: overrun
// - Abort command while busy sets abort flag
// - Any LIN error returns to withdrawal command
// - Writing one to summary clears all errors
// - Break-in-data aborts; bit or framing error reported
// - Checksum is inverted carry-wrapped byte sum
// - Four flags, each enabled, drive two interrupts
// - Frame status code marks identifiers 3C..3F
// - Checksum kind fixed on entering response command
// - Eight-byte buffer via index, optional auto-increment
// - UART data port is one unbuffered register
// - Busy bit shows communication in progress
package lus_pkg;
	localparam logic [7:0] LUS_OFS_CTRL = 8'h00;
	localparam logic [7:0] LUS_OFS_STATUS = 8'h04;
	localparam logic [7:0] LUS_OFS_IEN = 8'h08;
	localparam logic [7:0] LUS_OFS_ERR = 8'h0C;
	localparam logic [7:0] LUS_OFS_LEN = 8'h10;
	localparam logic [7:0] LUS_OFS_ID = 8'h14;
	localparam logic [7:0] LUS_OFS_SEL = 8'h18;
	localparam logic [7:0] LUS_OFS_DATA = 8'h1C;
	localparam logic [7:0] LUS_CKS_OK = 8'hFF;
	localparam logic [3:0] LUS_LEN_MAX = 4'h8;
	localparam logic [3:0] LUS_SPECIAL_ID = 4'hF;
	localparam logic [1:0] LUS_CONF_NOCRC = 2'h1;
	localparam logic [1:0] LUS_CONF_NOTO = 2'h2;
	localparam logic [2:0] LUS_CMD_RXHDR = 3'h0;
	localparam logic [2:0] LUS_CMD_TXHDR = 3'h1;
	localparam logic [2:0] LUS_CMD_RXRSP = 3'h2;
	localparam logic [2:0] LUS_CMD_TXRSP = 3'h3;

	typedef enum logic [2:0] {
		LUS_PH_IDLE = 3'b000,
		LUS_PH_HDR = 3'b001,
		LUS_PH_RSP_RX = 3'b010,
		LUS_PH_RSP_TX = 3'b011,
		LUS_PH_UART_TX = 3'b100
	} lus_phase_e;

	typedef struct packed {
		logic sw_reset;
		logic protocol_version_bit;
		logic [1:0] conf;
		logic enable;
		logic [2:0] command_field;
	} lus_ctrl_s;

	typedef struct packed {
		logic [2:0] frame_status_code;
		logic busy_status_bit;
		logic error_summary_bit;
		logic identifier_ok_flag;
		logic transmit_complete_flag;
		logic receive_complete_flag;
	} lus_status_s;

	typedef struct packed {
		logic abort_flag;
		logic timeout_error_flag;
		logic overrun_error_flag;
		logic framing_error_flag;
		logic sync_error_flag;
		logic parity_error_flag;
		logic checksum_error_flag;
		logic bit_error_flag;
	} lus_err_s;

	typedef struct packed {
		logic [3:0] tx_length_field;
		logic [3:0] rx_length_field;
	} lus_len_s;

	typedef struct packed {
		logic auto_increment_disable;
		logic [2:0] buffer_index;
	} lus_sel_s;

	// Events reported by the serial engine, one-cycle pulses with data
	typedef struct packed {
		logic hdr_done;
		logic [7:0] hdr_pid;
		logic rx_byte_vld;
		logic [7:0] rx_byte;
		logic tx_byte_done;
		logic bit_vld;
		logic bit_drv;
		logic bit_smp;
		logic sync_bad;
		logic stop_dominant;
		logic frame_over;
		logic break_sync;
	} lus_evt_s;

	typedef struct packed {
		logic start;
		logic stop;
		logic [2:0] command_field;
		logic [1:0] conf;
		logic [7:0] tx_byte;
		logic [7:0] tx_pid;
	} lus_eng_s;

	function automatic logic [7:0] lus_cks_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	function automatic logic [7:0] lus_pid(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction
endpackage

// ==== tb/lus_link_model.sv ====
// Far-side serial engine model: emits event pulses toward the block
module lus_link_model (
	input wire logic pclk,
	output lus_pkg::lus_evt_s evt
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		evt = '0;
	end

	// Gap models a slow engine; data lines show the inverse once released
	task automatic pulse(input lus_pkg::lus_evt_s e, input int gap);
		lus_pkg::lus_evt_s idle;
		idle = '0;
		idle.hdr_pid = ~e.hdr_pid;
		idle.rx_byte = ~e.rx_byte;
		idle.bit_drv = ~e.bit_drv;
		idle.bit_smp = ~e.bit_smp;
		repeat (gap) @(posedge pclk);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= idle;
	endtask
endmodule // lus_link_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the LIN/UART status, error and buffer block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	lus_pkg::lus_evt_s evt;
	lus_pkg::lus_eng_s eng;
	logic irq_ok;
	logic irq_err;
	int mismatches = 0;
	int check_count = 0;
	logic [7:0] rv;
	logic ev;
	logic [5:0] id;
	lus_pkg::lus_evt_s e;

	initial begin
		forever #10 pclk = ~pclk;
	end

	lus_core dut (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.evt(evt),
		.eng(eng),
		.irq_ok(irq_ok),
		.irq_err(irq_err)
	);

	lus_link_model m (
		.pclk(pclk),
		.evt(evt)
	);

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp(input logic [7:0] g, input logic [7:0] x, input logic [7:0] mk);
		check_count++;
		if ((g & mk) !== (x & mk)) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h mask %h", $time, g, x, mk);
		end
	endtask

	// One idle cycle between transfers keeps psel from being driven twice per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			@(posedge pclk);
		end
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic chk(input logic [7:0] a, input logic [7:0] x, input logic [7:0] mk);
		apb(1'h0, a, 8'h00);
		cmp(rv, x, mk);
	endtask

	task automatic send(input int k, input logic [7:0] b);
		e = '0;
		case (k)
			0: e.stop_dominant = 1'h1;
			1: e.frame_over = 1'h1;
			2: e.break_sync = 1'h1;
			3: begin
				e.bit_vld = 1'h1;
				e.bit_drv = 1'h1;
				e.bit_smp = b[0];
			end
			4: e.sync_bad = 1'h1;
			6: begin
				e.rx_byte_vld = 1'h1;
				e.rx_byte = b;
			end
			7: begin
				e.hdr_done = 1'h1;
				e.hdr_pid = b;
			end
			default: e.tx_byte_done = 1'h1;
		endcase
		m.pulse(e, k % 3);
	endtask

	task automatic errev(input logic [7:0] c, input int k, input logic [7:0] b, input logic [7:0] x);
		wr(lus_pkg::LUS_OFS_CTRL, c);
		send(k, b);
		chk(lus_pkg::LUS_OFS_ERR, x, 8'hFF);
		chk(lus_pkg::LUS_OFS_STATUS, (x != 8'h00) ? 8'h00 : 8'h10, 8'h10);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h00);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h08);
	endtask

	task automatic txstep(input logic [7:0] x);
		repeat (2) @(posedge pclk);
		cmp(eng.tx_byte, x, 8'hFF);
		send(8, 8'h00);
	endtask

	function automatic logic [7:0] pid(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), ^{i[0], i[1], i[2], i[4]}, i};
	endfunction

	initial begin
		e = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		chk(lus_pkg::LUS_OFS_STATUS, 8'h00, 8'hFF);
		chk(lus_pkg::LUS_OFS_LEN, 8'h00, 8'hFF);
		apb(1'h0, 8'h20, 8'h00);
		cmp({7'h00, ev}, 8'h01, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			id = (i == 4) ? 6'h10 : 6'h3C + 6'(i);
			wr(lus_pkg::LUS_OFS_IEN, i[0] ? 8'h0B : 8'h0F);
			wr(lus_pkg::LUS_OFS_CTRL, 8'h00);
			wr(lus_pkg::LUS_OFS_CTRL, 8'h08);
			send(7, pid(id));
			chk(lus_pkg::LUS_OFS_STATUS, (i == 4) ? 8'h04 : {1'h1, id[1:0], 5'h04},
				(i == 4) ? 8'h84 : 8'hE4);
			cmp({7'h00, irq_ok}, {7'h00, ~i[0]}, 8'hFF);
			wr(lus_pkg::LUS_OFS_STATUS, 8'h04);
		end
		wr(lus_pkg::LUS_OFS_CTRL, 8'h00);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h08);
		send(7, pid(6'h3C) ^ 8'h80);
		chk(lus_pkg::LUS_OFS_ERR, 8'h04, 8'hFF);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h08, 8'h08);
		cmp({7'h00, irq_err}, 8'h01, 8'hFF);
		chk(lus_pkg::LUS_OFS_CTRL, 8'h08, 8'h0F);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h08);
		chk(lus_pkg::LUS_OFS_ERR, 8'h00, 8'hFF);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h00, 8'h08);
		// Classic checksum response, two bytes
		wr(lus_pkg::LUS_OFS_CTRL, 8'h00);
		wr(lus_pkg::LUS_OFS_SEL, 8'h00);
		wr(lus_pkg::LUS_OFS_LEN, 8'h02);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h4A);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h10, 8'h10);
		send(6, 8'h12);
		send(6, 8'h34);
		send(6, 8'hB9);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h01, 8'h1B);
		chk(lus_pkg::LUS_OFS_LEN, 8'h22, 8'hFF);
		chk(lus_pkg::LUS_OFS_DATA, 8'h12, 8'hFF);
		chk(lus_pkg::LUS_OFS_DATA, 8'h34, 8'hFF);
		wr(lus_pkg::LUS_OFS_SEL, 8'h09);
		chk(lus_pkg::LUS_OFS_DATA, 8'h34, 8'hFF);
		chk(lus_pkg::LUS_OFS_DATA, 8'h34, 8'hFF);
		wr(lus_pkg::LUS_OFS_SEL, 8'h07);
		chk(lus_pkg::LUS_OFS_DATA, 8'h00, 8'hFF);
		chk(lus_pkg::LUS_OFS_DATA, 8'h12, 8'hFF);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h01);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h4A);
		send(6, 8'h12);
		send(6, 8'h34);
		send(6, 8'h00);
		chk(lus_pkg::LUS_OFS_ERR, 8'h02, 8'hFF);
		chk(lus_pkg::LUS_OFS_CTRL, 8'h48, 8'hFF);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h08);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h4A);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h4B);
		chk(lus_pkg::LUS_OFS_ERR, 8'h20, 8'hFF);
		chk(lus_pkg::LUS_OFS_CTRL, 8'h48, 8'hFF);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h4A);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h48);
		chk(lus_pkg::LUS_OFS_ERR, 8'hA0, 8'hFF);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h00, 8'h10);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h49);
		chk(lus_pkg::LUS_OFS_CTRL, 8'h49, 8'hFF);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h00);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h08);
		errev(8'h4A, 0, 8'h00, 8'h10);
		errev(8'h4A, 1, 8'h00, 8'h40);
		errev(8'h6A, 1, 8'h00, 8'h00);
		errev(8'h4A, 2, 8'h00, 8'h10);
		errev(8'h4B, 3, 8'h00, 8'h01);
		errev(8'h4B, 3, 8'h01, 8'h00);
		errev(8'h4B, 2, 8'h00, 8'h01);
		errev(8'h08, 4, 8'h00, 8'h08);
		// Enhanced checksum covers the protected identifier
		wr(lus_pkg::LUS_OFS_ID, 8'h10);
		chk(lus_pkg::LUS_OFS_ID, 8'h50, 8'hFF);
		wr(lus_pkg::LUS_OFS_SEL, 8'h00);
		wr(lus_pkg::LUS_OFS_DATA, 8'hF0);
		wr(lus_pkg::LUS_OFS_DATA, 8'h20);
		wr(lus_pkg::LUS_OFS_LEN, 8'h20);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h0B);
		txstep(8'hF0);
		txstep(8'h20);
		txstep(8'h9E);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h02, 8'h12);
		chk(lus_pkg::LUS_OFS_LEN, 8'h22, 8'hFF);
		cmp(eng.tx_pid, 8'h50, 8'hFF);
		cmp({7'h00, irq_ok}, 8'h01, 8'hFF);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h06);
		// Character mode
		wr(lus_pkg::LUS_OFS_CTRL, 8'h0F);
		wr(lus_pkg::LUS_OFS_LEN, 8'h35);
		chk(lus_pkg::LUS_OFS_LEN, 8'h00, 8'hFF);
		wr(lus_pkg::LUS_OFS_SEL, 8'h03);
		wr(lus_pkg::LUS_OFS_DATA, 8'h5A);
		txstep(8'h5A);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h02, 8'h17);
		send(7, 8'h50);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h00, 8'h04);
		send(6, 8'h3C);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h01, 8'h01);
		chk(lus_pkg::LUS_OFS_DATA, 8'h3C, 8'hFF);
		send(6, 8'h11);
		send(6, 8'h22);
		chk(lus_pkg::LUS_OFS_ERR, 8'h20, 8'hFF);
		chk(lus_pkg::LUS_OFS_DATA, 8'h22, 8'hFF);
		wr(lus_pkg::LUS_OFS_STATUS, 8'h08);
		errev(8'h0F, 0, 8'h00, 8'h10);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h4F);
		// Frozen block must miss a stop-bit event
		@(posedge pclk);
		ce <= 1'h0;
		send(0, 8'h00);
		cmp({7'h00, pready}, 8'h00, 8'hFF);
		@(posedge pclk);
		ce <= 1'h1;
		chk(lus_pkg::LUS_OFS_ERR, 8'h00, 8'hFF);
		wr(lus_pkg::LUS_OFS_CTRL, 8'h80);
		chk(lus_pkg::LUS_OFS_CTRL, 8'h00, 8'hFF);
		chk(lus_pkg::LUS_OFS_STATUS, 8'h00, 8'hFF);
		tally_and_finish();
	end

	// Whole sequence needs about five hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_top
